// ### include/intc_cfg.svh
/*
 * Address map, reset values and source map of the interrupt front end.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define SRC_COUNT          32
`define WORD_WIDTH         32

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADDR_NORMAL_STATUS 32'hfffff000
`define ADDR_FAST_STATUS   32'hfffff004
`define ADDR_RAW_STATUS    32'hfffff008
`define ADDR_CLASS_SELECT  32'hfffff00c
`define ADDR_ENABLE_SET    32'hfffff010
`define ADDR_ENABLE_CLEAR  32'hfffff014
`define ADDR_FORCE_SET     32'hfffff018
`define ADDR_FORCE_CLEAR   32'hfffff01c

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define RESET_WORD         32'h00000000
`define READ_NONE          32'h00000000
// hardware request lines wired: all but bit 1 and bits 22 to 31
`define SRC_USED_MASK      32'h003ffffd

`endif

// ### include/intc_pkg.sv
/*
 * Types shared by the interrupt front end modules.
 * Assumes intc_cfg.svh on the include path.
 */
`include "intc_cfg.svh"

package intc_pkg;

	// ------------------------------------------------------------------
	// vectors and bus bundles
	// ------------------------------------------------------------------
	typedef logic [`SRC_COUNT-1:0]  src_vec_t;
	typedef logic [`WORD_WIDTH-1:0] word_t;

	typedef struct packed {
		logic  psel;
		logic  penable;
		logic  pwrite;
		word_t paddr;
		word_t pwdata;
	} apb_req_s;

	typedef struct packed {
		logic normal_status;
		logic fast_status;
		logic raw_status;
		logic class_select;
		logic enable_set;
		logic enable_clear;
		logic force_set;
		logic force_clear;
	} reg_sel_s;

endpackage : intc_pkg

// ### hw/apb_decode.sv
/*
 * Address decoder of the register slave: one select per register.
 * Assumes a full 32-bit byte address from the bus request bundle.
 */
`timescale 1ns/1ps
`include "intc_cfg.svh"

module apb_decode
	import intc_pkg::*;
(
	input  apb_req_s req,
	output reg_sel_s sel,
	output logic     unmapped
);

	// ------------------------------------------------------------------
	// full address compare
	// ------------------------------------------------------------------
	assign sel.normal_status = (req.paddr == `ADDR_NORMAL_STATUS);
	assign sel.fast_status   = (req.paddr == `ADDR_FAST_STATUS);
	assign sel.raw_status    = (req.paddr == `ADDR_RAW_STATUS);
	assign sel.class_select  = (req.paddr == `ADDR_CLASS_SELECT);
	assign sel.enable_set    = (req.paddr == `ADDR_ENABLE_SET);
	assign sel.enable_clear  = (req.paddr == `ADDR_ENABLE_CLEAR);
	assign sel.force_set     = (req.paddr == `ADDR_FORCE_SET);
	assign sel.force_clear   = (req.paddr == `ADDR_FORCE_CLEAR);

	// no register hit at all
	assign unmapped = ~|sel;

endmodule : apb_decode

// ### hw/source_combine.sv
/*
 * Per-source combining: request or force, then enable and class routing.
 * Assumes requests are synchronous to the register clock.
 */
`timescale 1ns/1ps
`include "intc_cfg.svh"

module source_combine
	import intc_pkg::*;
(
	input  src_vec_t hw_request,
	input  src_vec_t force_bits,
	input  src_vec_t enable,
	input  src_vec_t select,
	output src_vec_t raw,
	output src_vec_t fast_pending,
	output src_vec_t normal_pending
);

	// unwired positions never carry a hardware request
	src_vec_t wired_request;
	assign wired_request = hw_request & `SRC_USED_MASK;

	// ------------------------------------------------------------------
	// one slice per source
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `SRC_COUNT; i++) begin : g_src
			// force joins before anything else looks at it
			assign raw[i] = wired_request[i] | force_bits[i];
			// only enabled sources pass, class picks the output
			assign fast_pending[i] = raw[i] & enable[i] & select[i];
			assign normal_pending[i] = raw[i] & enable[i] & ~select[i];
		end
	endgenerate

endmodule : source_combine

// ### hw/interrupt_enable_classify.sv
/*
 * Interrupt front end: raw status, enable mask, fast/normal classing,
 * software force, reached over an APB slave.
 * Assumes a single clock, requests synchronous to it, and an APB master
 * that keeps its request steady until pready.
 */
// Notes on behaviour
// - raw status read-only, ignores enable and class
// - enable read shows sources allowed to interrupt
// - enable write sets ones, zeros unchanged
// - enable clear is write-only, ones disable
// - zeros written to enable clear change nothing
// - one clear write suffices, no read first
// - only enabled sources reach either output
// - class select is read/write, one bit each
// - select zero normal, select one fast
// - force bits ORed into requests first
// - normal status is enabled normal-class sources
`timescale 1ns/1ps
`include "intc_cfg.svh"

module interrupt_enable_classify
	import intc_pkg::*;
(
	input  logic     pclk,
	input  logic     presetn,
	input  logic     pclken,
	input  logic     psel,
	input  logic     penable,
	input  logic     pwrite,
	input  word_t    paddr,
	input  word_t    pwdata,
	output word_t    prdata,
	output logic     pready,
	output logic     pslverr,
	input  src_vec_t source_request,
	output logic     fast_interrupt_out,
	output logic     normal_interrupt_out
);

	// ------------------------------------------------------------------
	// state and nets
	// ------------------------------------------------------------------
	src_vec_t fast_normal_select;
	src_vec_t source_enable_set;
	src_vec_t software_force_bits;
	logic     data_ready;

	src_vec_t raw_request_status;
	src_vec_t fast_pending;
	src_vec_t normal_pending;
	apb_req_s req;
	reg_sel_s sel;
	logic     unmapped;
	logic     access;
	logic     done;
	logic     wr_done;
	logic     load;
	word_t    read_word;
	src_vec_t next_select;
	src_vec_t next_enable;
	src_vec_t next_force;
	logic     next_data_ready;

	// ------------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------------
	// bundle the bus request for the decoder
	assign req = {psel, penable, pwrite, paddr, pwdata};

	apb_decode u_decode (
		.req      (req),
		.sel      (sel),
		.unmapped (unmapped)
	);

	source_combine u_combine (
		.hw_request     (source_request),
		.force_bits     (software_force_bits),
		.enable         (source_enable_set),
		.select         (fast_normal_select),
		.raw            (raw_request_status),
		.fast_pending   (fast_pending),
		.normal_pending (normal_pending)
	);

	// ------------------------------------------------------------------
	// bus phases
	// ------------------------------------------------------------------
	// access completes only on an enabled edge with data captured
	assign access  = psel & penable;
	assign pready  = pclken & data_ready;
	assign done    = access & pready;
	assign wr_done = done & pwrite;
	assign load    = pclken & psel & ~data_ready;
	assign pslverr = access & unmapped; // error on unmapped address
	assign next_data_ready = psel & ~done;

	// ------------------------------------------------------------------
	// read selection
	// ------------------------------------------------------------------
	// write-only registers read as zero
	assign read_word =
		({`WORD_WIDTH{sel.normal_status}} & normal_pending) |
		({`WORD_WIDTH{sel.fast_status}}   & fast_pending) |
		({`WORD_WIDTH{sel.raw_status}}    & raw_request_status) |
		({`WORD_WIDTH{sel.class_select}}  & fast_normal_select) |
		({`WORD_WIDTH{sel.enable_set}}    & source_enable_set) |
		({`WORD_WIDTH{sel.force_set}}     & software_force_bits);

	// ------------------------------------------------------------------
	// next register values
	// ------------------------------------------------------------------
	// class select takes the word as written
	assign next_select = (wr_done & sel.class_select) ? pwdata
		: fast_normal_select;

	// set register ORs ones in, clear register ANDs them out
	assign next_enable =
		(wr_done & sel.enable_set) ? (source_enable_set | pwdata)
		: (wr_done & sel.enable_clear) ? (source_enable_set & ~pwdata)
		: source_enable_set;

	// force bits use the same set and clear pairing
	assign next_force =
		(wr_done & sel.force_set) ? (software_force_bits | pwdata)
		: (wr_done & sel.force_clear) ? (software_force_bits & ~pwdata)
		: software_force_bits;

	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	// frozen while pclken is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_normal_select  <= `RESET_WORD;
			source_enable_set   <= `RESET_WORD;
			software_force_bits <= `RESET_WORD;
		end else if (pclken) begin
			fast_normal_select  <= next_select;
			source_enable_set   <= next_enable;
			software_force_bits <= next_force;
		end
	end

	// ------------------------------------------------------------------
	// bus response
	// ------------------------------------------------------------------
	// read data captured once per transfer, zero for writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= `READ_NONE;
			data_ready <= 1'b0;
		end else if (pclken) begin
			data_ready <= next_data_ready;
			if (load) begin
				prdata <= pwrite ? `READ_NONE : read_word;
			end
		end
	end

	// ------------------------------------------------------------------
	// interrupt outputs
	// ------------------------------------------------------------------
	// one registered level per class
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_interrupt_out   <= 1'b0;
			normal_interrupt_out <= 1'b0;
		end else if (pclken) begin
			fast_interrupt_out   <= |fast_pending;
			normal_interrupt_out <= |normal_pending;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// raw read ignores enable and class
	property p_raw_read;
		@(posedge pclk) disable iff (!presetn)
		(load && !pwrite && sel.raw_status)
		|=> (prdata == $past(raw_request_status));
	endproperty
	a_raw_read: assert property (p_raw_read)
		else $error("raw status read mismatch");

	// enable read shows the mask
	property p_enable_read;
		@(posedge pclk) disable iff (!presetn)
		(load && !pwrite && sel.enable_set)
		|=> (prdata == $past(source_enable_set));
	endproperty
	a_enable_read: assert property (p_enable_read)
		else $error("enable read mismatch");

	// set write ORs in the ones
	property p_enable_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel.enable_set)
		|=> (source_enable_set
			== ($past(source_enable_set) | $past(pwdata)));
	endproperty
	a_enable_set: assert property (p_enable_set)
		else $error("enable set write wrong");

	// clear write removes ones, keeps zeros
	property p_enable_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel.enable_clear)
		|=> (source_enable_set
			== ($past(source_enable_set) & ~$past(pwdata)));
	endproperty
	a_enable_clear: assert property (p_enable_clear)
		else $error("enable clear write wrong");

	// no enable bit turns on without a set write
	property p_clear_keeps;
		@(posedge pclk) disable iff (!presetn)
		(pclken && !(wr_done && sel.enable_set))
		|=> ((source_enable_set & ~$past(source_enable_set))
			== `RESET_WORD);
	endproperty
	a_clear_keeps: assert property (p_clear_keeps)
		else $error("enable bit set without set write");

	// a cleared source stops reaching the outputs two edges on
	property p_clear_blocks;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel.enable_clear && (pwdata == ~`RESET_WORD))
		##1 pclken
		|=> (!fast_interrupt_out && !normal_interrupt_out);
	endproperty
	a_clear_blocks: assert property (p_clear_blocks)
		else $error("single clear write did not silence outputs");

	// outputs follow enabled class-routed sources
	property p_outputs;
		@(posedge pclk) disable iff (!presetn)
		pclken
		|=> ((fast_interrupt_out
			== |($past(raw_request_status) & $past(source_enable_set)
				& $past(fast_normal_select)))
		&& (normal_interrupt_out
			== |($past(raw_request_status) & $past(source_enable_set)
				& ~$past(fast_normal_select))));
	endproperty
	a_outputs: assert property (p_outputs)
		else $error("interrupt output not from enabled sources");

	// class select write stores the word
	property p_select_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel.class_select)
		|=> (fast_normal_select == $past(pwdata));
	endproperty
	a_select_write: assert property (p_select_write)
		else $error("class select write wrong");

	// fast output only from select-one sources
	property p_fast_class;
		@(posedge pclk) disable iff (!presetn)
		(pclken && ((source_enable_set & fast_normal_select)
			== `RESET_WORD))
		|=> !fast_interrupt_out;
	endproperty
	a_fast_class: assert property (p_fast_class)
		else $error("fast output without fast-class source");

	// force bits appear in raw status
	property p_force_or;
		@(posedge pclk) disable iff (!presetn)
		((software_force_bits & ~raw_request_status) == `RESET_WORD);
	endproperty
	a_force_or: assert property (p_force_or)
		else $error("forced bit missing from raw status");

	// normal status read
	property p_normal_read;
		@(posedge pclk) disable iff (!presetn)
		(load && !pwrite && sel.normal_status)
		|=> (prdata == $past(raw_request_status & source_enable_set
			& ~fast_normal_select));
	endproperty
	a_normal_read: assert property (p_normal_read)
		else $error("normal status read mismatch");

	// unwired lines never show without force
	property p_map;
		@(posedge pclk) disable iff (!presetn)
		((raw_request_status & ~`SRC_USED_MASK & ~software_force_bits)
			== `RESET_WORD);
	endproperty
	a_map: assert property (p_map)
		else $error("unused source bit active");

	// raw bit tracks the combined request
	property p_raw_level;
		@(posedge pclk) disable iff (!presetn)
		(raw_request_status
			== ((source_request & `SRC_USED_MASK) | software_force_bits));
	endproperty
	a_raw_level: assert property (p_raw_level)
		else $error("raw status not equal to combined request");

	// state frozen while the clock enable is low
	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!pclken
		|=> ($stable(source_enable_set) && $stable(fast_normal_select)
			&& $stable(software_force_bits) && $stable(prdata));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state changed with clock enable low");

	// fast status read
	property p_fast_read;
		@(posedge pclk) disable iff (!presetn)
		(load && !pwrite && sel.fast_status)
		|=> (prdata == $past(raw_request_status & source_enable_set
			& fast_normal_select));
	endproperty
	a_fast_read: assert property (p_fast_read)
		else $error("fast status read mismatch");

	// zeros written to the clear word keep their enable bits
	property p_clear_zero;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel.enable_clear)
		|=> (((source_enable_set ^ $past(source_enable_set))
			& ~$past(pwdata)) == `RESET_WORD);
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("enable bit changed by a zero in clear");

	// write-only clear words read back as zero
	property p_wo_read;
		@(posedge pclk) disable iff (!presetn)
		(load && !pwrite && (sel.enable_clear || sel.force_clear))
		|=> (prdata == `READ_NONE);
	endproperty
	a_wo_read: assert property (p_wo_read)
		else $error("write-only register read not zero");

	// writes to raw status change no stored state
	property p_raw_ro;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel.raw_status)
		|=> ($stable(source_enable_set) && $stable(fast_normal_select)
			&& $stable(software_force_bits));
	endproperty
	a_raw_ro: assert property (p_raw_ro)
		else $error("write to raw status changed state");

endmodule : interrupt_enable_classify

// ### tb/core_model.sv
/*
 * Behavioural processor core that takes the fast and normal interrupts.
 * Assumes level interrupts, active high, synchronous to pclk.
 */
`timescale 1ns/1ps

module core_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       fast_irq,
	input  wire logic       normal_irq,
	output logic      [7:0] fast_taken,
	output logic      [7:0] normal_taken
);
	// ------------------------------------------------------------------
	// interrupt entry
	// ------------------------------------------------------------------
	logic fast_q;
	logic normal_q;

	// one entry counted on each rising level, as a core would vector once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_q       <= 1'b0;
			normal_q     <= 1'b0;
			fast_taken   <= 8'h00;
			normal_taken <= 8'h00;
		end else begin
			fast_q   <= fast_irq;
			normal_q <= normal_irq;
			if (fast_irq && !fast_q) begin
				fast_taken <= fast_taken + 8'h01;
			end
			if (normal_irq && !normal_q) begin
				normal_taken <= normal_taken + 8'h01;
			end
		end
	end
endmodule : core_model

// ### tb/tb_top.sv
/*
 * Self-checking bench of the interrupt front end over APB.
 * Assumes intc_pkg, intc_cfg.svh and core_model compiled before it.
 */
`timescale 1ns/1ps
`include "intc_cfg.svh"

module tb_top
	import intc_pkg::*;
;
	// ------------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------------
	logic     pclk;
	logic     presetn;
	logic     pclken;
	logic     psel;
	logic     penable;
	logic     pwrite;
	word_t    paddr;
	word_t    pwdata;
	word_t    prdata;
	logic     pready;
	logic     pslverr;
	src_vec_t source_request;
	logic     fast_interrupt_out;
	logic     normal_interrupt_out;
	logic [7:0] fast_taken;
	logic [7:0] normal_taken;
	int       mismatches;
	int       compares;
	int       waits;
	word_t    rd;
	logic     err;

	interrupt_enable_classify DUT (.pclk(pclk), .presetn(presetn),
		.pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .source_request(source_request),
		.fast_interrupt_out(fast_interrupt_out),
		.normal_interrupt_out(normal_interrupt_out));

	core_model core (.pclk(pclk), .presetn(presetn),
		.fast_irq(fast_interrupt_out), .normal_irq(normal_interrupt_out),
		.fast_taken(fast_taken), .normal_taken(normal_taken));

	// 20 mhz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task test_done;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	task check(input word_t got, input word_t exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one apb transfer; answer taken at the edge where pready is high
	task apb(input logic wr, input word_t addr, input word_t wdata);
		logic done;
		done = 1'b0;
		waits = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				rd   = prdata;
				err  = pslverr;
				done = 1'b1;
			end else begin
				waits++;
			end
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		if (!done) begin
			mismatches++;
			$display("ERROR t=%0t no pready", $time);
			test_done();
		end
	endtask : apb

	task wr32(input word_t addr, input word_t data);
		apb(1'b1, addr, data);
		check({31'h0, err}, 32'h0);
	endtask : wr32

	task rd_chk(input word_t addr, input word_t exp);
		apb(1'b0, addr, 32'h0);
		check({31'h0, err}, 32'h0);
		check(rd, exp);
	endtask : rd_chk

	// lets the registered interrupt outputs follow a change
	task settle;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	task drive_src(input src_vec_t v);
		@(posedge pclk);
		source_request <= v;
	endtask : drive_src

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task t_reset_values;
		for (int i = 0; i < 8; i++) begin
			rd_chk(`ADDR_NORMAL_STATUS + 32'(i * 4), `RESET_WORD);
		end
	endtask : t_reset_values

	task t_raw;
		drive_src(32'hffffffff);
		settle();
		rd_chk(`ADDR_RAW_STATUS, `SRC_USED_MASK);
		wr32(`ADDR_RAW_STATUS, 32'h00000000);
		rd_chk(`ADDR_RAW_STATUS, `SRC_USED_MASK);
		check({30'h0, fast_interrupt_out, normal_interrupt_out}, 32'h0);
		wr32(`ADDR_FORCE_SET, 32'h00000002);
		rd_chk(`ADDR_RAW_STATUS, `SRC_USED_MASK | 32'h2);
		drive_src(32'h00000000);
		settle();
		rd_chk(`ADDR_RAW_STATUS, 32'h00000002);
		wr32(`ADDR_FORCE_CLEAR, 32'h00000002);
		rd_chk(`ADDR_RAW_STATUS, 32'h00000000);
	endtask : t_raw

	task t_enable;
		wr32(`ADDR_ENABLE_SET, 32'h000000f0);
		wr32(`ADDR_ENABLE_SET, 32'h00000f00);
		rd_chk(`ADDR_ENABLE_SET, 32'h00000ff0);
		wr32(`ADDR_ENABLE_CLEAR, 32'h00000030);
		rd_chk(`ADDR_ENABLE_SET, 32'h00000fc0);
		rd_chk(`ADDR_ENABLE_CLEAR, `READ_NONE);
		wr32(`ADDR_ENABLE_CLEAR, 32'hffffffff);
		rd_chk(`ADDR_ENABLE_SET, 32'h00000000);
	endtask : t_enable

	task t_class;
		wr32(`ADDR_CLASS_SELECT, 32'h80000100);
		rd_chk(`ADDR_CLASS_SELECT, 32'h80000100);
		drive_src(32'h00000100);
		wr32(`ADDR_ENABLE_SET, 32'h00000100);
		settle();
		check({30'h0, fast_interrupt_out, normal_interrupt_out}, 32'h2);
		rd_chk(`ADDR_FAST_STATUS, 32'h00000100);
		rd_chk(`ADDR_NORMAL_STATUS, 32'h00000000);
		check({24'h0, fast_taken}, 32'h1);
		wr32(`ADDR_CLASS_SELECT, 32'h00000000);
		settle();
		check({30'h0, fast_interrupt_out, normal_interrupt_out}, 32'h1);
		rd_chk(`ADDR_NORMAL_STATUS, 32'h00000100);
		check({24'h0, normal_taken}, 32'h1);
		wr32(`ADDR_ENABLE_CLEAR, 32'h00000100);
		settle();
		check({30'h0, fast_interrupt_out, normal_interrupt_out}, 32'h0);
		rd_chk(`ADDR_RAW_STATUS, 32'h00000100);
		drive_src(32'h00000000);
	endtask : t_class

	task t_unmapped;
		apb(1'b1, 32'hfffff020, 32'hffffffff);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 32'hfffff020, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, `READ_NONE);
		rd_chk(`ADDR_ENABLE_SET, 32'h00000000);
	endtask : t_unmapped

	// clock enable low at the setup edge stretches the access phase
	task t_wait_state;
		wr32(`ADDR_CLASS_SELECT, 32'h5a5a5a5a);
		@(posedge pclk);
		pclken <= 1'b0;
		fork
			apb(1'b0, `ADDR_CLASS_SELECT, 32'h0);
			begin
				repeat (5) @(posedge pclk);
				pclken <= 1'b1;
			end
		join
		check({31'h0, waits >= 2}, 32'h1);
		check(rd, 32'h5a5a5a5a);
		wr32(`ADDR_CLASS_SELECT, 32'h00000000);
	endtask : t_wait_state

	// reset in mid-run brings registers and outputs back to zero
	task t_mid_reset;
		wr32(`ADDR_CLASS_SELECT, 32'h00000001);
		wr32(`ADDR_ENABLE_SET, 32'h00000001);
		wr32(`ADDR_FORCE_SET, 32'h00000001);
		settle();
		check({30'h0, fast_interrupt_out, normal_interrupt_out}, 32'h2);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check({30'h0, fast_interrupt_out, normal_interrupt_out}, 32'h0);
		t_reset_values();
	endtask : t_mid_reset

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		mismatches     = 0;
		compares       = 0;
		presetn        = 1'b0;
		pclken         = 1'b1;
		psel           = 1'b0;
		penable        = 1'b0;
		pwrite         = 1'b0;
		paddr          = 32'h00000000;
		pwdata         = 32'h00000000;
		source_request = 32'h00000000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_raw();
		t_enable();
		t_class();
		t_unmapped();
		t_wait_state();
		t_mid_reset();
		test_done();
	end
endmodule : tb_top
